//--- rtl/spi_fram_pkg.sv
// shared constants for the serial ferroelectric memory link and its controller
package spi_fram_pkg;
    // operation codes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD = 8'h03;
    localparam logic [7:0] OP_ARR_WR = 8'h02;
    // status register bit positions
    localparam int ST_LOCK = 7;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_LATCH = 1;
    // array geometry and guarded ranges
    localparam int MEM_AW = 12;
    localparam logic [11:0] GUARD_QTR_BASE = 12'hc00;
    localparam logic [11:0] GUARD_HALF_BASE = 12'h800;
    // serial clock made by the controller
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCK_HALF_NS = 320;
    localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_PERIOD_NS;
    // controller registers, byte addresses
    localparam int AXI_AW = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0c;
    localparam logic [4:0] REG_STAT = 5'h10;
    localparam logic [4:0] REG_PINS = 5'h14;
    // control register fields, pins register reset value and response codes
    localparam int CTRL_SEND_OP = 8;
    localparam int CTRL_SEND_ADDR = 9;
    localparam int CTRL_NB_LSB = 10;
    localparam int CTRL_KEEP_CS = 13;
    localparam logic [1:0] PINS_RST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/spi_fram_if.sv
// serial link between the memory device end and the controller end
`timescale 1ns/1ps
`default_nettype none
interface spi_fram_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic miso_d;
    logic miso_oe_n;
    logic miso;
    // a pull-up holds the line high while the device floats it
    assign miso = miso_oe_n ? 1'b1 : miso_d;
    modport dev (
        input cs_n, sck, mosi, hold_n, wp_n,
        output miso_d, miso_oe_n
    );
    modport host (
        output cs_n, sck, mosi, hold_n, wp_n,
        input miso
    );
endinterface
`default_nettype wire

//--- rtl/spi_fram_dev.sv
// memory device end: command decode, status register, guarded array
//
// Functional notes
// RQ1 - unknown opcode: ignore rest until deselect
// RQ2 - 06 latch set, 04 clear, 05 status read
// RQ3 - 01 status write, 03 read, 02 write
// RQ4 - latch set enables writes; clear refuses them
// RQ5 - latch clear blocks later writes
// RQ6 - status read repeats freely, no side effects
// RQ7 - status write touches lock and guards only
// RQ8 - read: opcode, 16-bit address, data out
// RQ9 - read address increments each byte, wraps
// RQ10 - master ends read on last bit
// RQ11 - write stores bytes, increments, wraps to zero
// RQ12 - master ends write after data byte
// RQ13 - guard bits select protected upper range
// RQ14 - lock clear: guards writable regardless pin
// RQ15 - soft mode: status writable with latch
// RQ16 - hard mode: status writes all rejected
// RQ17 - hold floats output, ignores input
// RQ18 - latch cleared by reset, clear, writes
// RQ19 - sample rising, shift falling, modes 0/3
// RQ20 - status lost at power-off, rewrite after
// RQ21 - msb first, low 12 address bits used
// RQ22 - lock b7, guards b3/b2, progress zero
`timescale 1ns/1ps
`default_nettype none
module spi_fram_dev
    import spi_fram_pkg::*;
#(
    parameter int ADDR_W = MEM_AW
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // serial link
    spi_fram_if.dev bus,
    // observation
    output logic [7:0] status_out,
    output logic selected_out
);
    typedef enum logic [2:0] {
        S_OPC, S_ADDR, S_RD, S_WR, S_SRD, S_SWR, S_IGN
    } dev_state_e;

    typedef struct packed {
        dev_state_e st;
        logic [2:0] bit_cnt;
        logic addr_hi_done;
        logic is_read;
        logic [7:0] rx;
        logic [ADDR_W-1:0] addr;
        logic [7:0] tx;
        logic miso;
        logic miso_oe_n;
        logic latch;
        logic lock;
        logic g_hi;
        logic g_lo;
        logic wr_seen;
        logic sel;
        logic [1:0] sck_s;
        logic [1:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] hold_s;
        logic [1:0] wp_s;
        logic sck_prev;
    } dev_s;

    dev_s r;
    dev_s n;
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0] byte_in;
    logic rise;
    logic fall;
    logic live;

    function automatic logic [7:0] status_byte(input dev_s s);
        status_byte = 8'h00;
        status_byte[ST_LOCK] = s.lock; // RQ22
        status_byte[ST_GUARD_HI] = s.g_hi;
        status_byte[ST_GUARD_LO] = s.g_lo;
        status_byte[ST_LATCH] = s.latch;
    endfunction

    function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic hi,
                                     input logic lo);
        case ({hi, lo})
            2'b00: guarded = 1'b0;
            2'b01: guarded = a >= ADDR_W'(GUARD_QTR_BASE); // RQ13
            2'b10: guarded = a >= ADDR_W'(GUARD_HALF_BASE);
            default: guarded = 1'b1;
        endcase
    endfunction

    always_comb begin
        n = r;
        // pins pass two flops before anything looks at them
        n.sck_s = {r.sck_s[0], bus.sck};
        n.cs_s = {r.cs_s[0], bus.cs_n};
        n.mosi_s = {r.mosi_s[0], bus.mosi};
        n.hold_s = {r.hold_s[0], bus.hold_n};
        n.wp_s = {r.wp_s[0], bus.wp_n};
        n.sck_prev = r.sck_s[1];
        rise = r.sck_s[1] & ~r.sck_prev;
        fall = ~r.sck_s[1] & r.sck_prev;
        live = ~r.cs_s[1] & r.hold_s[1]; // RQ17
        byte_in = {r.rx[6:0], r.mosi_s[1]}; // RQ21
        mem_we = 1'b0;
        mem_wa = r.addr;
        n.sel = ~r.cs_s[1];
        if (r.cs_s[1]) begin
            if (r.st == S_WR && r.wr_seen) begin
                n.latch = 1'b0; // RQ18
            end
            n.st = S_OPC;
            n.bit_cnt = 3'd0;
            n.addr_hi_done = 1'b0;
            n.wr_seen = 1'b0;
        end else if (live && rise) begin // RQ19
            n.rx = byte_in;
            n.bit_cnt = r.bit_cnt + 3'd1;
            if (r.bit_cnt == 3'd7) begin
                case (r.st)
                    S_OPC: begin
                        case (byte_in)
                            OP_LATCH_SET: begin
                                n.latch = 1'b1; // RQ2 RQ4
                                n.st = S_IGN;
                            end
                            OP_LATCH_CLR: begin
                                n.latch = 1'b0; // RQ2 RQ5 RQ18
                                n.st = S_IGN;
                            end
                            OP_STAT_RD: begin
                                n.tx = status_byte(r); // RQ2 RQ6
                                n.st = S_SRD;
                            end
                            OP_STAT_WR: n.st = S_SWR; // RQ3
                            OP_ARR_RD, OP_ARR_WR: begin
                                n.is_read = (byte_in == OP_ARR_RD); // RQ3
                                n.st = S_ADDR;
                            end
                            default: n.st = S_IGN; // RQ1
                        endcase
                    end
                    S_ADDR: begin
                        if (!r.addr_hi_done) begin
                            // upper address bits above the array are dropped
                            n.addr[ADDR_W-1:8] = byte_in[ADDR_W-9:0]; // RQ21
                            n.addr_hi_done = 1'b1;
                        end else begin
                            n.addr[7:0] = byte_in; // RQ8
                            n.st = r.is_read ? S_RD : S_WR;
                            if (r.is_read) begin
                                n.tx = mem[{r.addr[ADDR_W-1:8], byte_in}]; // RQ8
                            end
                        end
                    end
                    S_RD: begin
                        n.addr = r.addr + ADDR_W'(1); // RQ9
                        n.tx = mem[r.addr + ADDR_W'(1)]; // RQ9
                    end
                    S_WR: begin
                        // refused bytes still advance the address
                        mem_we = r.latch && !guarded(r.addr, r.g_hi, r.g_lo); // RQ4 RQ13
                        n.addr = r.addr + ADDR_W'(1); // RQ11
                        n.wr_seen = 1'b1;
                    end
                    S_SRD: n.tx = status_byte(r); // RQ6
                    S_SWR: begin
                        // hard mode needs the pin low and the lock set
                        if (r.latch && !(~r.wp_s[1] && r.lock)) begin // RQ14 RQ15 RQ16
                            n.lock = byte_in[ST_LOCK]; // RQ7
                            n.g_hi = byte_in[ST_GUARD_HI];
                            n.g_lo = byte_in[ST_GUARD_LO];
                        end
                        n.latch = 1'b0; // RQ18
                        n.st = S_IGN;
                    end
                    S_IGN: n.st = S_IGN; // RQ1
                    default: n.st = S_IGN;
                endcase
            end
        end else if (live && fall && (r.st == S_RD || r.st == S_SRD)) begin // RQ19
            n.miso = r.tx[7]; // RQ21
            n.tx = {r.tx[6:0], 1'b0};
        end
        // enabled together with the first bit, so no stale level shows while the clock is high
        if (!(live && (r.st == S_RD || r.st == S_SRD))) begin
            n.miso_oe_n = 1'b1; // RQ17
        end else if (fall) begin
            n.miso_oe_n = 1'b0; // RQ19
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // status is volatile: every reset starts it cleared
            r <= '0; // RQ20
            r.miso_oe_n <= 1'b1;
            r.cs_s <= 2'h3;
            r.hold_s <= 2'h3;
            r.wp_s <= 2'h3;
        end else begin
            r <= n;
        end
    end

    // the array keeps its contents across reset, as the cells are nonvolatile
    always_ff @(posedge sys_clk_in) begin
        if (mem_we) begin
            mem[mem_wa] <= byte_in; // RQ11
        end
    end

    assign bus.miso_d = r.miso;
    assign bus.miso_oe_n = r.miso_oe_n;
    assign status_out = status_byte(r);
    assign selected_out = r.sel;
endmodule // spi_fram_dev
`default_nettype wire

//--- rtl/spi_fram_host.sv
// controller end: register-driven serial master over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module spi_fram_host
    import spi_fram_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // write address and data
    input wire logic [AXI_AW-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    // write response
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // read
    input wire logic [AXI_AW-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // serial link
    spi_fram_if.host bus
);
    typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} host_state_e;

    typedef struct packed {
        host_state_e st;
        logic [7:0] div;
        logic go;
        logic sck;
        logic cs_n;
        logic mosi;
        logic [55:0] tx;
        logic [5:0] bits;
        logic [31:0] rx;
        logic [13:0] ctrl;
        logic [15:0] addr;
        logic [31:0] wd;
        logic [1:0] pins;
        logic [1:0] miso_s;
        logic [AXI_AW-1:0] awaddr;
        logic aw_got;
        logic [31:0] wbuf;
        logic w_got;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } host_s;

    host_s r;
    host_s n;
    logic tick;
    logic [31:0] wb;

    function automatic logic known(input logic [AXI_AW-1:0] a);
        known = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_WDATA) ||
                (a == REG_RDATA) || (a == REG_STAT) || (a == REG_PINS);
    endfunction

    always_comb begin
        n = r;
        n.miso_s = {r.miso_s[0], bus.miso};
        tick = (r.div == 8'(HALF_CYC - 1));
        n.div = tick ? 8'h00 : r.div + 8'h01;
        // first data byte goes out from the low byte of the data register
        wb = {r.wd[7:0], r.wd[15:8], r.wd[23:16], r.wd[31:24]};
        // write channel: address and data taken in either order
        if (awvalid_in && r.awready) begin
            n.awaddr = awaddr_in;
            n.aw_got = 1'b1;
        end
        if (wvalid_in && r.wready) begin
            n.wbuf = wdata_in;
            n.w_got = 1'b1;
        end
        if (r.bvalid && bready_in) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = known(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            case (r.awaddr)
                REG_CTRL: begin
                    // a command written while busy is dropped
                    if (r.st == H_IDLE && !r.go) begin
                        n.ctrl = r.wbuf[13:0];
                        n.go = 1'b1;
                    end
                end
                REG_ADDR: n.addr = r.wbuf[15:0];
                REG_WDATA: n.wd = r.wbuf;
                REG_PINS: n.pins = r.wbuf[1:0];
                default: n.bresp = n.bresp;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        // read channel
        if (r.rvalid && rready_in) begin
            n.rvalid = 1'b0;
        end
        if (arvalid_in && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = known(araddr_in) ? RESP_OKAY : RESP_SLVERR;
            case (araddr_in)
                REG_CTRL: n.rdata = {18'h0, r.ctrl};
                REG_ADDR: n.rdata = {16'h0, r.addr};
                REG_WDATA: n.rdata = r.wd;
                REG_RDATA: n.rdata = r.rx;
                REG_STAT: n.rdata = {31'h0, (r.st != H_IDLE) || r.go};
                REG_PINS: n.rdata = {30'h0, r.pins};
                default: n.rdata = 32'h0;
            endcase
        end
        n.arready = !n.rvalid;
        // serial engine, mode 0: shift on falling, sample on rising
        if (tick) begin
            case (r.st)
                H_IDLE: begin
                    if (r.go) begin
                        n.go = 1'b0;
                        n.cs_n = 1'b0;
                        n.bits = (r.ctrl[CTRL_SEND_OP] ? 6'd8 : 6'd0) +
                                 (r.ctrl[CTRL_SEND_ADDR] ? 6'd16 : 6'd0) +
                                 {r.ctrl[CTRL_NB_LSB +: 3], 3'b000};
                        case ({r.ctrl[CTRL_SEND_OP], r.ctrl[CTRL_SEND_ADDR]})
                            2'b11: n.tx = {r.ctrl[7:0], r.addr, wb};
                            2'b10: n.tx = {r.ctrl[7:0], wb, 16'h0};
                            2'b01: n.tx = {r.addr, wb, 8'h0};
                            default: n.tx = {wb, 24'h0};
                        endcase
                        n.mosi = n.tx[55];
                        n.tx = {n.tx[54:0], 1'b0};
                        n.st = (n.bits == 6'd0) ? H_END : H_RUN;
                    end
                end
                H_RUN: begin
                    if (!r.sck) begin
                        n.sck = 1'b1;
                        n.rx = {r.rx[30:0], r.miso_s[1]};
                        n.bits = r.bits - 6'd1;
                    end else begin
                        n.sck = 1'b0;
                        if (r.bits == 6'd0) begin
                            n.st = H_END;
                        end else begin
                            n.mosi = r.tx[55];
                            n.tx = {r.tx[54:0], 1'b0};
                        end
                    end
                end
                H_END: begin
                    // cs rises only after the last byte, so writes end cleanly
                    n.cs_n = ~r.ctrl[CTRL_KEEP_CS]; // RQ10 RQ12
                    n.st = H_IDLE;
                end
                default: n.st = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '0;
            r.cs_n <= 1'b1;
            r.pins <= PINS_RST;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign awready_out = r.awready;
    assign wready_out = r.wready;
    assign bvalid_out = r.bvalid;
    assign bresp_out = r.bresp;
    assign arready_out = r.arready;
    assign rvalid_out = r.rvalid;
    assign rdata_out = r.rdata;
    assign rresp_out = r.rresp;
    assign bus.cs_n = r.cs_n;
    assign bus.sck = r.sck;
    assign bus.mosi = r.mosi;
    assign bus.wp_n = r.pins[1];
    assign bus.hold_n = r.pins[0];
endmodule // spi_fram_host
`default_nettype wire

//--- bench/spi_fram_assertions.sv
// concurrent checks on the serial link joining the controller and the device
`timescale 1ns/1ps
`default_nettype none
module spi_fram_assertions
    import spi_fram_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // serial link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic miso_d,
    input wire logic miso_oe_n
);
    logic sck_q;
    logic rise;
    logic [15:0] bit_cnt;
    logic [7:0] op_sr;
    logic [7:0] op_now;
    logic bad_op;

    assign rise = sck & ~sck_q;
    assign op_now = {op_sr[6:0], mosi};

    // bits are counted on the raw pin; the device sees them a few clocks later
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_q <= 1'b0;
            bit_cnt <= 16'h0000;
            op_sr <= 8'h00;
            bad_op <= 1'b0;
        end else begin
            sck_q <= sck;
            if (cs_n) begin
                bit_cnt <= 16'h0000;
                bad_op <= 1'b0;
            end else if (rise) begin
                bit_cnt <= bit_cnt + 16'h0001;
                op_sr <= op_now;
                if (bit_cnt == 16'h0007 && hold_n)
                    bad_op <= !(op_now inside {OP_LATCH_SET, OP_LATCH_CLR, OP_STAT_RD,
                        OP_STAT_WR, OP_ARR_RD, OP_ARR_WR});
            end
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sck_in_frame_a: assert property ($changed(sck) |-> !cs_n)
        else $error("serial clock moved while deselected");
    sck_high_a: assert property ($rose(sck) |=> sck [*7] ##1 !sck)
        else $error("serial clock high phase has wrong length");
    mosi_steady_a: assert property (sck |-> $stable(mosi))
        else $error("serial input changed while clock high");
    miso_shift_a: assert property ($changed(miso_d) && !miso_oe_n |-> !sck)
        else $error("serial output changed while clock high");
    byte_frame_a: assert property ($rose(cs_n) |-> bit_cnt[2:0] == 3'h0)
        else $error("frame ended inside a byte");
    drive_start_a: assert property ($fell(miso_oe_n) |->
        !sck && bit_cnt >= 16'h0008 && bit_cnt[2:0] == 3'h0)
        else $error("device began driving off a byte boundary");
    deselect_float_a: assert property (cs_n [*6] |-> miso_oe_n)
        else $error("device drives while deselected");
    hold_float_a: assert property (!hold_n [*6] |-> miso_oe_n)
        else $error("device drives during pause");
    bad_op_quiet_a: assert property (bad_op |-> miso_oe_n)
        else $error("device answered an unknown command");
endmodule // spi_fram_assertions
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench: controller and memory device joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module testbench
    import spi_fram_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [4:0] araddr = 5'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, selected;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] status;
    int err_total = 0;
    int num_checks = 0;

    always #20 sys_clk_in = ~sys_clk_in;

    spi_fram_if link ();
    spi_fram_dev spi_fram_dev_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus(link),
        .status_out(status), .selected_out(selected));
    spi_fram_host spi_fram_host_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
        .wstrb_in(4'hf), .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
        .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
        .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
        .rready_in(rready), .bus(link));
    spi_fram_assertions spi_fram_assertions_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi), .hold_n(link.hold_n),
        .miso_d(link.miso_d), .miso_oe_n(link.miso_oe_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic give_up();
        err_total++;
        $display("Error at %0t: wait ran out", $time);
        end_of_test();
    endtask

    // handshakes are judged at the falling edge, so the rising edge decides cleanly;
    // response readies stay high between calls, so none is driven twice in one step
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ta, tw, done;
        n = 0;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk_in);
            n++;
            if (n > 1000) give_up();
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            resp = bresp;
            @(posedge sys_clk_in);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ta, done;
        n = 0;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk_in);
            n++;
            if (n > 1000) give_up();
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge sys_clk_in);
            if (ta) arvalid <= 1'b0;
        end
    endtask

    // writing the control word starts a frame; busy is polled until it drops
    task automatic run(input logic [31:0] c, output logic [31:0] rd);
        logic [1:0] r;
        logic [31:0] s;
        int n;
        n = 0;
        axi_wr(REG_CTRL, c, r);
        do begin
            axi_rd(REG_STAT, s, r);
            n++;
        end while (s[0] !== 1'b0 && n < 500);
        if (s[0] !== 1'b0) give_up();
        axi_rd(REG_RDATA, rd, r);
    endtask

    task automatic xfer(input logic [7:0] op, input logic [2:0] nb, input logic [15:0] ad,
            input logic [31:0] wd, output logic [31:0] rd);
        logic [1:0] r;
        axi_wr(REG_ADDR, {16'h0000, ad}, r);
        axi_wr(REG_WDATA, wd, r);
        run({18'h0, 1'b0, nb, (op == OP_ARR_RD || op == OP_ARR_WR), 1'b1, op}, rd);
    endtask

    task automatic stat_wr(input logic [7:0] v);
        logic [31:0] rd;
        xfer(OP_LATCH_SET, 3'h0, 16'h0, 32'h0, rd);
        xfer(OP_STAT_WR, 3'h1, 16'h0, {24'h0, v}, rd);
    endtask

    task automatic arr_wr(input logic [15:0] a, input logic [2:0] nb, input logic [31:0] d);
        logic [31:0] rd;
        xfer(OP_LATCH_SET, 3'h0, 16'h0, 32'h0, rd);
        xfer(OP_ARR_WR, nb, a, d, rd);
    endtask

    initial begin
        logic [31:0] rd;
        logic [1:0] r;
        logic [7:0] mem [4];
        logic [11:0] ga [4];
        logic [7:0] v;
        ga = '{12'h7ff, 12'h800, 12'hbff, 12'hc00};
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        check({24'h0, status}, 32'h0);
        axi_rd(REG_PINS, rd, r);
        check(rd, {30'h0, PINS_RST});
        axi_rd(5'h18, rd, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(5'h1c, 32'h0, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        xfer(OP_LATCH_SET, 3'h0, 16'h0, 32'h0, rd);
        xfer(OP_STAT_RD, 3'h2, 16'h0, 32'h0, rd);
        check({16'h0, rd[15:0]}, 32'h0202);
        xfer(OP_LATCH_CLR, 3'h0, 16'h0, 32'h0, rd);
        xfer(OP_STAT_RD, 3'h1, 16'h0, 32'h0, rd);
        check({24'h0, rd[7:0]}, 32'h0);
        arr_wr(16'h0010, 3'h1, 32'h5a);
        check({24'h0, status}, 32'h0);
        // latch is clear here, so this byte must be dropped
        xfer(OP_ARR_WR, 3'h1, 16'h0010, 32'ha5, rd);
        xfer(OP_ARR_RD, 3'h1, 16'h0010, 32'h0, rd);
        check({24'h0, rd[7:0]}, 32'h5a);
        arr_wr(16'hfffe, 3'h4, 32'h44332211);
        xfer(OP_ARR_RD, 3'h4, 16'h0ffe, 32'h0, rd);
        check(rd, 32'h11223344);
        // select held low across two commands: the read runs on and wraps
        axi_wr(REG_ADDR, 32'h0ffe, r);
        run({18'h0, 4'h9, 2'h3, OP_ARR_RD}, rd);
        check({24'h0, rd[7:0]}, 32'h11);
        run({18'h0, 4'h2, 2'h0, 8'h00}, rd);
        check({16'h0, rd[15:0]}, 32'h2233);
        for (int g = 0; g < 4; g++) begin
            stat_wr({4'h0, g[1:0], 2'b00});
            check({24'h0, status}, {26'h0, g[1:0], 4'h0} >> 2);
            v = 8'(g * 16);
            arr_wr(16'h07ff, 3'h2, {16'h0, v + 8'h2, v + 8'h1});
            arr_wr(16'h0bff, 3'h2, {16'h0, v + 8'h4, v + 8'h3});
            for (int k = 0; k < 4; k++) begin
                if (!(g == 3 || (g == 2 && ga[k] >= GUARD_HALF_BASE) ||
                        (g == 1 && ga[k] >= GUARD_QTR_BASE))) mem[k] = v + 8'(k + 1);
            end
            xfer(OP_ARR_RD, 3'h2, 16'h07ff, 32'h0, rd);
            check({16'h0, rd[15:0]}, {16'h0, mem[0], mem[1]});
            xfer(OP_ARR_RD, 3'h2, 16'h0bff, 32'h0, rd);
            check({16'h0, rd[15:0]}, {16'h0, mem[2], mem[3]});
        end
        stat_wr(8'hf4);
        check({24'h0, status}, 32'h84);
        axi_wr(REG_PINS, 32'h1, r);
        stat_wr(8'h00);
        check({24'h0, status}, 32'h84);
        arr_wr(16'h0100, 3'h1, 32'h3c);
        xfer(OP_ARR_RD, 3'h1, 16'h0100, 32'h0, rd);
        check({24'h0, rd[7:0]}, 32'h3c);
        axi_wr(REG_PINS, 32'h3, r);
        stat_wr(8'h00);
        check({24'h0, status}, 32'h0);
        axi_wr(REG_PINS, 32'h1, r);
        stat_wr(8'h08);
        check({24'h0, status}, 32'h08);
        axi_wr(REG_PINS, 32'h3, r);
        xfer(8'h0b, 3'h1, 16'h0, 32'h0, rd);
        check({24'h0, rd[7:0]}, 32'hff);
        // pause held across whole frames: opcode must be ignored, output floats high
        axi_wr(REG_PINS, 32'h2, r);
        xfer(OP_LATCH_SET, 3'h0, 16'h0, 32'h0, rd);
        check({24'h0, status}, 32'h08);
        xfer(OP_STAT_RD, 3'h1, 16'h0, 32'h0, rd);
        check({24'h0, rd[7:0]}, 32'hff);
        axi_wr(REG_PINS, 32'h3, r);
        // a reset between frames, with the controller idle, clears the status but leaves the array intact
        rst_n_in <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        check({24'h0, status}, 32'h0);
        xfer(OP_ARR_RD, 3'h1, 16'h0100, 32'h0, rd);
        check({24'h0, rd[7:0]}, 32'h3c);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
